// ### verilog/wct_pkg.sv
// Package: register map, field positions, reset values and timing for the trigger controller
package wct_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_DELAY = 8'h0c;
    localparam logic [7:0] ADDR_INHIBIT = 8'h10;
    localparam logic [7:0] ADDR_DURATION = 8'h14;
    localparam logic [7:0] ADDR_WAVE_LEN = 8'h18;
    localparam logic [7:0] ADDR_SAMPLE_DIV = 8'h1c;
    localparam logic [7:0] ADDR_ACT_DELAY = 8'h20;
    // Control and command register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_EXT = 3;
    localparam int CTRL_SYNC_OUT = 4;
    localparam int CTRL_POL_FALL = 5;
    localparam int CTRL_DLY_TIME = 6;
    localparam int CTRL_DUR_WAVE = 7;
    localparam int CMD_EXEC = 0;
    localparam int CMD_ARM = 1;
    // Reset values: retrigger mode, internal source, synchronous output on
    localparam logic [7:0] CTRL_RESET = 8'h11;
    localparam logic [31:0] DIV_RESET = 32'h0000_0001;
    localparam logic [31:0] WAVE_LEN_RESET = 32'h0000_0400;
    // Clock period, engine processing latency and bus response codes
    localparam logic [31:0] CLK_PERIOD_NS = 32'h0000_000a;
    localparam logic [31:0] LATENCY_SAMPLES = 32'h0000_0010;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Trigger modes and controller states
    localparam logic [2:0] MODE_AUTO = 3'h0;
    localparam logic [2:0] MODE_RETRIG = 3'h1;
    localparam logic [2:0] MODE_ARMED_AUTO = 3'h2;
    localparam logic [2:0] MODE_ARMED_RETRIG = 3'h3;
    localparam logic [2:0] MODE_SINGLE = 3'h4;
    typedef enum logic [2:0] {
        ST_STOPPED = 3'b001,
        ST_DELAY = 3'b010,
        ST_RUN = 3'b100
    } wct_st_t;
endpackage : wct_pkg

// ### verilog/wct_count.sv
// Down-counter with busy level and terminal pulse, stepped by an enable
`timescale 1ns/1ps
module wct_count (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic load,
    input wire logic [31:0] load_val,
    input wire logic tick,
    // Status
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [31:0] cnt;
        logic busy;
        logic done;
    } wct_cnt_state_t;

    wct_cnt_state_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (load) begin
            s_nxt.cnt = load_val;
        end else if (tick && s_r.cnt != 32'h0) begin
            s_nxt.cnt = s_r.cnt - 32'h1;
            s_nxt.done = (s_r.cnt == 32'h1);
        end
        s_nxt.busy = (s_nxt.cnt != 32'h0);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign done = s_r.done;
endmodule : wct_count

// ### verilog/wct_trigger_ctrl.sv
// Trigger controller for the waveform playback engine, with AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Retrigger mode plays continuously; each accepted trigger restarts from start.
// - Armed-auto waits idle for first trigger, then plays continuously.
// - Armed-retrigger starts on first trigger; later triggers restart playback.
// - Arm, only while running in armed modes, stops output until next trigger.
// - Single mode waits for trigger, plays once for duration; triggers restart it.
// - Duration and its unit apply only in single mode; samples or waveforms.
// - Running status shown; while stopped output disabled, awaiting a trigger.
// - Manual trigger works only with internal source and mode not auto.
// - Internal source triggers by command only; external by selected input edge.
// - Sync output, external only, default on: start at trigger, drop latency.
// - Sync off: output waits out latency and starts at sample zero.
// - Delay unit selects samples or time entry; delay shown converted to time.
// - External trigger action is postponed by the programmed delay.
// - Read-only register gives the effective external delay as time.
// - After a trigger, further triggers ignored for inhibit sample count.
// - Auto mode plays at once and ignores all triggers.
// - Armed-auto ignores triggers once playback has started.
module wct_trigger_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External trigger pin
    input wire logic ext_trig_in,
    // Playback engine control
    output logic sample_tick,
    output logic play_restart,
    output logic play_advance,
    output logic play_out_en,
    output logic running
);
    typedef struct packed {
        wct_pkg::wct_st_t st;
        logic [1:0] trig_sync;
        logic trig_d;
        logic [31:0] div_cnt;
        logic tick;
        logic [7:0] ctrl;
        logic [31:0] delay;
        logic [31:0] inhibit;
        logic [31:0] duration;
        logic [31:0] wave_len;
        logic [31:0] div;
        logic awready;
        logic wready;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic restart;
        logic advance;
        logic out_en;
        logic lat_run;
    } wct_state_t;

    wct_state_t s_r, s_nxt;
    logic dly_busy, dly_done, inh_busy, dur_busy, dur_done, lat_busy;
    logic fire, dly_load, dly_tick;
    logic [31:0] dur_len, act_delay;
    function automatic logic [31:0] wct_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[8*i +: 8] = data[8*i +: 8];
            end
        end
        return v;
    endfunction : wct_merge

    //////////////////////////////////////////////////////////////////////////
    // Sample-period counters
    // delay counts samples, or clock cycles when the time unit is selected
    assign dly_tick = s_r.ctrl[wct_pkg::CTRL_DLY_TIME] ? 1'b1 : s_r.tick;
    // duration in samples or whole waveforms
    assign dur_len = s_r.ctrl[wct_pkg::CTRL_DUR_WAVE] ? 32'(s_r.duration * s_r.wave_len)
                                                       : s_r.duration;
    assign act_delay = s_r.ctrl[wct_pkg::CTRL_DLY_TIME]
                     ? 32'(s_r.delay * wct_pkg::CLK_PERIOD_NS)
                     : 32'(s_r.delay * s_r.div * wct_pkg::CLK_PERIOD_NS);

    wct_count u_delay (
        .clock(clock), .rst_n(rst_n), .load(dly_load), .load_val(s_r.delay),
        .tick(dly_tick), .busy(dly_busy), .done(dly_done)
    );
    wct_count u_inhibit (
        .clock(clock), .rst_n(rst_n), .load(fire), .load_val(s_r.inhibit),
        .tick(s_r.tick), .busy(inh_busy), .done()
    );
    wct_count u_duration (
        .clock(clock), .rst_n(rst_n), .load(fire), .load_val(dur_len),
        .tick(s_r.tick), .busy(dur_busy), .done(dur_done)
    );
    wct_count u_latency (
        .clock(clock), .rst_n(rst_n), .load(fire), .load_val(wct_pkg::LATENCY_SAMPLES),
        .tick(s_r.tick), .busy(lat_busy), .done()
    );

    //////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic [2:0] mode;
        logic ext, wr, exec, arm, edge_seen, trig, accept, was_run;
        s_nxt = s_r;
        mode = s_r.ctrl[wct_pkg::CTRL_MODE_LSB +: 3];
        ext = s_r.ctrl[wct_pkg::CTRL_SRC_EXT];
        wr = !s_r.awready && !s_r.wready && !s_r.bvalid;
        exec = 1'b0;
        arm = 1'b0;
        trig = 1'b0;
        accept = 1'b0;
        was_run = (s_r.st == wct_pkg::ST_RUN);
        edge_seen = 1'b0;
        fire = 1'b0;
        dly_load = 1'b0;
        s_nxt.restart = 1'b0;

        // Sample-rate enable from the divider
        s_nxt.tick = 1'b0;
        if (s_r.div_cnt + 32'h1 >= s_r.div) begin
            s_nxt.div_cnt = 32'h0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + 32'h1;
        end

        // Pin synchroniser; edge taken from the second stage only
        s_nxt.trig_sync = {s_r.trig_sync[0], ext_trig_in};
        s_nxt.trig_d = s_r.trig_sync[1];
        // active edge of the external input
        edge_seen = s_r.ctrl[wct_pkg::CTRL_POL_FALL] ? (s_r.trig_d && !s_r.trig_sync[1])
                                                     : (!s_r.trig_d && s_r.trig_sync[1]);

        // AXI write: address and data accepted in either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.waddr = s_axi_awaddr;
            s_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
            s_nxt.wready = 1'b0;
        end
        if (wr) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wct_pkg::RESP_OKAY;
            unique case (s_r.waddr)
                wct_pkg::ADDR_CTRL: begin
                    s_nxt.ctrl = 8'(wct_merge({24'h0, s_r.ctrl}, s_r.wdata, s_r.wstrb));
                    // Mode change drops playback; auto and retrigger modes restart it below
                    if (s_nxt.ctrl[2:0] != mode) begin
                        s_nxt.st = wct_pkg::ST_STOPPED;
                    end
                end
                wct_pkg::ADDR_CMD: begin
                    exec = s_r.wstrb[0] && s_r.wdata[wct_pkg::CMD_EXEC];
                    arm = s_r.wstrb[0] && s_r.wdata[wct_pkg::CMD_ARM];
                end
                wct_pkg::ADDR_STATUS, wct_pkg::ADDR_ACT_DELAY: ;
                wct_pkg::ADDR_DELAY: s_nxt.delay = wct_merge(s_r.delay, s_r.wdata, s_r.wstrb);
                wct_pkg::ADDR_INHIBIT:
                    s_nxt.inhibit = wct_merge(s_r.inhibit, s_r.wdata, s_r.wstrb);
                wct_pkg::ADDR_DURATION:
                    s_nxt.duration = wct_merge(s_r.duration, s_r.wdata, s_r.wstrb);
                wct_pkg::ADDR_WAVE_LEN:
                    s_nxt.wave_len = wct_merge(s_r.wave_len, s_r.wdata, s_r.wstrb);
                wct_pkg::ADDR_SAMPLE_DIV:
                    s_nxt.div = wct_merge(s_r.div, s_r.wdata, s_r.wstrb);
                default: s_nxt.bresp = wct_pkg::RESP_SLVERR;
            endcase
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
        end

        // AXI read
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = wct_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                wct_pkg::ADDR_CTRL: s_nxt.rdata = {24'h0, s_r.ctrl};
                wct_pkg::ADDR_CMD: s_nxt.rdata = 32'h0;
                wct_pkg::ADDR_STATUS: s_nxt.rdata = {28'h0, s_r.st, running};
                wct_pkg::ADDR_DELAY: s_nxt.rdata = s_r.delay;
                wct_pkg::ADDR_INHIBIT: s_nxt.rdata = s_r.inhibit;
                wct_pkg::ADDR_DURATION: s_nxt.rdata = s_r.duration;
                wct_pkg::ADDR_WAVE_LEN: s_nxt.rdata = s_r.wave_len;
                wct_pkg::ADDR_SAMPLE_DIV: s_nxt.rdata = s_r.div;
                wct_pkg::ADDR_ACT_DELAY: s_nxt.rdata = act_delay;
                default: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rresp = wct_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end

        // manual trigger gated by source and mode
        // source selects command or pin edge
        trig = ext ? edge_seen : (exec && mode != wct_pkg::MODE_AUTO);
        accept = trig && !inh_busy && s_r.st != wct_pkg::ST_DELAY
              && mode != wct_pkg::MODE_AUTO
              && !(mode == wct_pkg::MODE_ARMED_AUTO && was_run);

        unique case (s_r.st)
            wct_pkg::ST_STOPPED: begin
                // retrigger and auto start at once
                if (mode == wct_pkg::MODE_AUTO || mode == wct_pkg::MODE_RETRIG) begin
                    fire = s_nxt.st == wct_pkg::ST_STOPPED;
                end
            end
            wct_pkg::ST_RUN: begin
                // arm stops only armed modes while running
                if (arm && (mode == wct_pkg::MODE_ARMED_AUTO ||
                            mode == wct_pkg::MODE_ARMED_RETRIG)) begin
                    s_nxt.st = wct_pkg::ST_STOPPED;
                end
                // single output ends after its duration
                if (mode == wct_pkg::MODE_SINGLE && (dur_done || !dur_busy) && !s_r.restart) begin
                    s_nxt.st = wct_pkg::ST_STOPPED;
                end
            end
            wct_pkg::ST_DELAY: begin
                if (dly_done) begin
                    fire = s_nxt.st == wct_pkg::ST_DELAY;
                end
            end
            default: s_nxt.st = wct_pkg::ST_STOPPED;
        endcase

        // accepted trigger starts or restarts playback
        if (accept && s_nxt.st == s_r.st) begin
            if (ext && s_r.delay != 32'h0) begin
                dly_load = 1'b1;
                s_nxt.st = wct_pkg::ST_DELAY;
            end else begin
                fire = 1'b1;
            end
        end

        // inhibit, duration and latency load when the trigger acts
        if (fire) begin
            s_nxt.st = wct_pkg::ST_RUN;
            s_nxt.restart = 1'b1;
            s_nxt.lat_run = 1'b1;
        end else if (!lat_busy) begin
            s_nxt.lat_run = 1'b0;
        end

        // sync output advances through the latency, dropping samples
        // otherwise engine holds at sample zero until latency is over
        if (s_nxt.st != wct_pkg::ST_RUN) begin
            s_nxt.advance = 1'b0;
            s_nxt.out_en = 1'b0;
        end else begin
            s_nxt.advance = (ext && s_r.ctrl[wct_pkg::CTRL_SYNC_OUT]) || !s_nxt.lat_run;
            // output disabled while stopped or filling
            s_nxt.out_en = !s_nxt.lat_run;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.st <= wct_pkg::ST_STOPPED;
            s_r.ctrl <= wct_pkg::CTRL_RESET;
            s_r.div <= wct_pkg::DIV_RESET;
            s_r.wave_len <= wct_pkg::WAVE_LEN_RESET;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign sample_tick = s_r.tick;
    assign play_restart = s_r.restart;
    assign play_advance = s_r.advance;
    assign play_out_en = s_r.out_en;
    assign running = s_r.st[2];
endmodule : wct_trigger_ctrl

// ### bench/wct_trigger_ctrl_asserts.sv
// Checker for the trigger controller port behaviour
`timescale 1ns/1ps
module wct_trigger_ctrl_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Playback control
    input wire logic play_restart,
    input wire logic play_advance,
    input wire logic play_out_en,
    input wire logic running
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_stopped;
        !running [*3];
    endsequence
    a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response not in time");
    a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    a_restart_pulse: assert property (play_restart |=> !play_restart)
        else $error("restart longer than one cycle");
    a_restart_runs: assert property (play_restart |-> running)
        else $error("restart without running");
    a_start_cause: assert property ($rose(running) |-> play_restart)
        else $error("running rose without restart");
    a_stop_mute: assert property (s_stopped |-> !play_out_en && !play_advance)
        else $error("output active while stopped");
endmodule : wct_trigger_ctrl_asserts

bind wct_trigger_ctrl wct_trigger_ctrl_asserts u_chk (.clock, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .play_restart, .play_advance, .play_out_en, .running);

// ### bench/wct_ext_src.sv
// External trigger source driving the trigger pin
`timescale 1ns/1ps
module wct_ext_src (
    // Clock
    input wire logic clock,
    // Request
    input wire logic fire,
    input wire logic pol_fall,
    input wire logic [3:0] hold,
    // Pin
    output logic ext_trig_in
);
    int cnt = 0;
    always @(posedge clock) begin
        if (fire && cnt == 0) cnt <= int'(hold) + 1;
        else if (cnt != 0) cnt <= cnt - 1;
    end
    // active edge polarity
    // Idle sits at the inactive level so each pulse opens with the chosen edge
    assign ext_trig_in = (cnt != 0) ^ pol_fall;
endmodule : wct_ext_src

// ### bench/tb_waveform_playback_trigger_control.sv
// Self-checking bench for the trigger controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
$display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_waveform_playback_trigger_control;
    logic clock = 0, rst_n = 0, fire = 0, pol = 0;
    logic [3:0] hold = 4'h3, s_axi_wstrb = 4'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic ext_trig_in, sample_tick, play_restart, play_advance, play_out_en, running;
    int error_cnt = 0, compares = 0, rs_cnt = 0, m_mode, m_ext, m_run, m_rs, n0, lat, dly;
    int m_inh = 0, tk_cnt = 0;
    always #5 clock = ~clock;
    always @(posedge clock) if (play_restart === 1'b1) rs_cnt++;
    always @(posedge clock) if (sample_tick === 1'b1) tk_cnt++;
    wct_trigger_ctrl dut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trig_in,
        .sample_tick, .play_restart, .play_advance, .play_out_en, .running);
    wct_ext_src u_src (.clock, .fire, .pol_fall(pol), .hold, .ext_trig_in);
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic pulse;
        @(posedge clock);
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
    endtask : pulse
    task automatic mdl(input int ev);
        m_rs = 0;
        if (ev == 1) begin
            if (m_run != 0 && (m_mode == 2 || m_mode == 3)) m_run = 0;
        end else if (m_inh == 0 && m_mode != 0 && int'(ev == 2) == m_ext
                     && !(m_mode == 2 && m_run != 0)) begin
            m_run = 1;
            m_rs = 1;
        end
    endtask : mdl
    // Event codes: 0 command trigger, 1 arm, 2 pin edge
    task automatic act(input int ev, input int w);
        n0 = rs_cnt;
        mdl(ev);
        if (ev == 2) pulse();
        else wr(wct_pkg::ADDR_CMD, (ev == 1) ? 32'h2 : 32'h1);
        repeat (w) @(posedge clock);
        `CHK("restarts", m_rs, rs_cnt - n0)
        `CHK("running", m_run[0], running)
    endtask : act
    initial begin
        #200us;
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        void'($urandom(32'h05139487));
        rd(wct_pkg::ADDR_CTRL);
        `CHK("ctrl", {24'h0, wct_pkg::CTRL_RESET}, rv)
        rd(wct_pkg::ADDR_SAMPLE_DIV);
        `CHK("div", wct_pkg::DIV_RESET, rv)
        rd(wct_pkg::ADDR_WAVE_LEN);
        `CHK("wlen", wct_pkg::WAVE_LEN_RESET, rv)
        rd(8'h24);
        `CHK("rd_err", wct_pkg::RESP_SLVERR, rr)
        wr(8'h28, 32'h1);
        `CHK("wr_err", wct_pkg::RESP_SLVERR, rr)
        `CHK("run_rst", 1'b1, running)
        rd(wct_pkg::ADDR_STATUS);
        `CHK("status", {28'h0, wct_pkg::ST_RUN, 1'b1}, rv)
        $display("test registers done");
        wr(wct_pkg::ADDR_DURATION, 32'h28);
        for (int m = 0; m < 5; m++) begin
            wr(wct_pkg::ADDR_CTRL, m);
            m_mode = m;
            m_ext = 0;
            m_run = int'(m < 2);
            repeat (10) @(posedge clock);
            `CHK("mode_run", m_run[0], running)
            act(0, 10);
            act(0, 10);
            repeat (100) @(posedge clock);
            if (m == 4) m_run = 0;
            `CHK("dur_run", m_run[0], running)
            act(1, 10);
        end
        $display("test modes done");
        for (int p = 0; p < 2; p++) begin
            dly = 1 + int'($urandom % 6);
            hold <= 4'h2 + 4'($urandom % 6);
            wr(wct_pkg::ADDR_DELAY, dly);
            wr(wct_pkg::ADDR_INHIBIT, 32'h14);
            wr(wct_pkg::ADDR_SAMPLE_DIV, 32'h2);
            // Counted between falling edges so both ends see the same side of a tick
            @(negedge clock);
            n0 = tk_cnt;
            repeat (20) @(negedge clock);
            `CHK("ticks", 10, tk_cnt - n0)
            wr(wct_pkg::ADDR_CTRL, (p == 0) ? 32'h1b : 32'h2b);
            pol <= p[0];
            m_mode = 3;
            m_ext = 1;
            m_run = 0;
            rd(wct_pkg::ADDR_ACT_DELAY);
            `CHK("act_dly", dly * 20, rv)
            act(0, 10);
            n0 = rs_cnt;
            mdl(2);
            pulse();
            lat = 1;
            while (play_restart !== 1'b1 && lat < 300) begin
                @(posedge clock);
                lat++;
            end
            `CHK("delay", 1'b1, lat >= dly * 2 + 2 && lat <= dly * 2 + 10)
            repeat (2) @(posedge clock);
            `CHK("advance", p == 0, play_advance)
            `CHK("out_en", 1'b0, play_out_en)
            m_inh = 1;
            act(2, dly * 2 + 12);
            m_inh = 0;
            lat = 0;
            while (play_out_en !== 1'b1 && lat < 100) begin
                @(posedge clock);
                lat++;
            end
            `CHK("out_on", 1'b1, play_out_en)
            // Inhibit of 20 samples at two clocks each has run out by now
            repeat (40) @(posedge clock);
            act(2, dly * 2 + 12);
            wr(wct_pkg::ADDR_CTRL, (p == 0) ? 32'h5b : 32'h6b);
            rd(wct_pkg::ADDR_ACT_DELAY);
            `CHK("act_time", dly * 10, rv)
            act(1, 10);
        end
        $display("test external done");
        conclude();
    end
endmodule : tb_waveform_playback_trigger_control
